// *** common/flow_pkg.sv ***
// shared types and constants for the controller data flow block
package flow_pkg;

	localparam int HANDLE_W      = 12;
	localparam int NUM_CONN      = 4;
	localparam int IDX_W         = 2;
	localparam int CNT_W         = 8;
	localparam int REPORT_PERIOD = 16'h0400;
	localparam int CNT_ZERO      = 0;

	typedef enum logic {
		LINK_ACL,
		LINK_SCO
	} link_type_t;

	// one data packet header crossing the controller
	typedef struct packed {
		logic [HANDLE_W-1:0] handle;
		link_type_t          kind;
	} pkt_hdr_t;

	// one entry of a completed-packet report
	typedef struct packed {
		logic [HANDLE_W-1:0] handle;
		logic [CNT_W-1:0]    count;
	} report_entry_t;

endpackage : flow_pkg

// *** src/conn_fifo.sv ***
// per-connection packet order queue
`timescale 1ns/10ps
module conn_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// write side
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	input  wire logic [WIDTH-1:0] wr_data,
	// read side
	output logic                  rd_valid,
	input  wire logic             rd_ready,
	output logic [WIDTH-1:0]      rd_data,
	// flush
	input  wire logic             flush
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("conn_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wptr_ff;
	logic [AW:0]      rptr_ff;

	assign wr_ready = (wptr_ff - rptr_ff) != (AW+1)'(DEPTH);
	assign rd_valid = wptr_ff != rptr_ff;
	assign rd_data  = mem_ff[rptr_ff[AW-1:0]];

	always_ff @(posedge clk) begin
		if (wr_valid && wr_ready) begin
			mem_ff[wptr_ff[AW-1:0]] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
		end else begin
			if (wr_valid && wr_ready) wptr_ff <= wptr_ff + 1'b1;
			if (rd_valid && rd_ready) rptr_ff <= rptr_ff + 1'b1;
		end
	end

endmodule : conn_fifo

// *** src/flow_ctrl.sv ***
// controller side data flow control and completed-packet reporting
//
// Contract
// - report completions while connected or looping back
// - report lists handle with count since last
// - keep reporting periodically while packets pending
// - omit sco handles when sco flow disabled
// - air transmit keeps per-handle host order
// - air receive forwarded in reception order
// - arbitrate per handle, never reorder within
`timescale 1ns/10ps
module flow_ctrl #(
	parameter int NUM_CONN   = flow_pkg::NUM_CONN,
	parameter int QDEPTH     = 4,
	parameter int PERIOD_CYC = flow_pkg::REPORT_PERIOD
) (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	// mode and connection table
	input  wire logic                           loopback_en,
	input  wire logic                           sco_flow_en,
	input  wire logic [NUM_CONN-1:0]            conn_open,
	input  wire logic [NUM_CONN-1:0]            conn_is_sco,
	input  wire logic [NUM_CONN*flow_pkg::HANDLE_W-1:0] conn_handle,
	// host to controller data packets
	input  wire logic                           h2c_valid,
	output logic                                h2c_ready,
	input  wire flow_pkg::pkt_hdr_t             h2c_hdr,
	// air transmit side
	output logic                                tx_valid,
	input  wire logic                           tx_ready,
	output flow_pkg::pkt_hdr_t                  tx_hdr,
	input  wire logic [NUM_CONN-1:0]            tx_flush,
	// air receive side to host
	input  wire logic                           rx_valid,
	output logic                                rx_ready,
	input  wire flow_pkg::pkt_hdr_t             rx_hdr,
	output logic                                c2h_valid,
	input  wire logic                           c2h_ready,
	output flow_pkg::pkt_hdr_t                  c2h_hdr,
	// completed-packet report stream
	output logic                                rpt_valid,
	input  wire logic                           rpt_ready,
	output flow_pkg::report_entry_t             rpt_entry,
	output logic                                rpt_last
);
	localparam int HW  = flow_pkg::HANDLE_W;
	localparam int CW  = flow_pkg::CNT_W;
	localparam int IW  = (NUM_CONN > 1) ? $clog2(NUM_CONN) : 1;
	localparam int PW  = $clog2(PERIOD_CYC + 1);
	localparam int HDW = $bits(flow_pkg::pkt_hdr_t);

	if (NUM_CONN < 1 || PERIOD_CYC < 1) begin : g_bad_param
		$error("flow_ctrl parameters out of range");
	end

	typedef enum logic [1:0] {
		RPT_IDLE,
		RPT_SEND
	} rpt_state_t;

	// match a handle to its connection slot
	function automatic logic [NUM_CONN-1:0] match_handle(
		input logic [HW-1:0] h,
		input logic [NUM_CONN*HW-1:0] tbl,
		input logic [NUM_CONN-1:0] open
	);
		logic [NUM_CONN-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_CONN; i++) begin
			m[i] = open[i] && (tbl[i*HW +: HW] == h);
		end
		return m;
	endfunction : match_handle

	function automatic logic [IW-1:0] first_set(input logic [NUM_CONN-1:0] v);
		logic [IW-1:0] r;
		r = '0;
		for (int i = NUM_CONN-1; i >= 0; i--) begin
			if (v[i]) r = IW'(i);
		end
		return r;
	endfunction : first_set

	////////////////////////////////////////////////////////////////////////////
	// per-connection order queues
	logic [NUM_CONN-1:0] in_match;
	logic [NUM_CONN-1:0] q_wr_ready;
	logic [NUM_CONN-1:0] q_rd_valid;
	logic [NUM_CONN-1:0] q_rd_ready;
	logic [HDW-1:0]      q_rd_data [NUM_CONN];
	logic [NUM_CONN-1:0] done_evt;

	assign in_match  = match_handle(h2c_hdr.handle, conn_handle, conn_open);
	assign h2c_ready = |(in_match & q_wr_ready);

	genvar g;
	generate
		for (g = 0; g < NUM_CONN; g++) begin : g_q
			conn_fifo #(.WIDTH(HDW), .DEPTH(QDEPTH)) u_q (
				.clk      (clk),
				.rst_n    (rst_n),
				.wr_valid (h2c_valid && in_match[g]),
				.wr_ready (q_wr_ready[g]),
				.wr_data  (h2c_hdr),
				.rd_valid (q_rd_valid[g]),
				.rd_ready (q_rd_ready[g]),
				.rd_data  (q_rd_data[g]),
				.flush    (tx_flush[g] || !conn_open[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// round-robin arbitration across handles, head-of-queue only
	logic [IW-1:0] rr_ff;
	logic [IW-1:0] sel;
	logic          sel_ok;
	logic          hold_ff;
	logic [IW-1:0] hold_sel_ff;

	always_comb begin
		sel    = '0;
		sel_ok = 1'b0;
		for (int k = NUM_CONN-1; k >= 0; k--) begin
			if (q_rd_valid[IW'((int'(rr_ff) + k) % NUM_CONN)]) begin
				sel    = IW'((int'(rr_ff) + k) % NUM_CONN);
				sel_ok = 1'b1;
			end
		end
		// an offered head stays offered until taken or flushed
		if (hold_ff && q_rd_valid[hold_sel_ff]) begin
			sel    = hold_sel_ff;
			sel_ok = 1'b1;
		end
	end

	assign tx_valid = sel_ok;
	assign tx_hdr   = flow_pkg::pkt_hdr_t'(q_rd_data[sel]);

	always_comb begin
		q_rd_ready = '0;
		if (sel_ok && tx_ready) q_rd_ready[sel] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) rr_ff <= '0;
		else if (sel_ok && tx_ready) rr_ff <= IW'((int'(sel) + 1) % NUM_CONN);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_ff     <= 1'b0;
			hold_sel_ff <= '0;
		end else begin
			hold_ff     <= sel_ok && !tx_ready;
			hold_sel_ff <= sel;
		end
	end

	// a flush counts as one completed packet, however many packets it drops
	generate
		for (g = 0; g < NUM_CONN; g++) begin : g_done
			assign done_evt[g] = q_rd_ready[g] ||
				(tx_flush[g] && q_rd_valid[g]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// receive path goes through one register stage in arrival order
	assign rx_ready  = c2h_ready || !c2h_valid;
	flow_pkg::pkt_hdr_t c2h_hdr_ff;
	logic               c2h_valid_ff;
	assign c2h_valid = c2h_valid_ff;
	assign c2h_hdr   = c2h_hdr_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			c2h_valid_ff <= 1'b0;
			c2h_hdr_ff   <= '0;
		end else if (rx_ready) begin
			c2h_valid_ff <= rx_valid;
			c2h_hdr_ff   <= rx_hdr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// completion counters since last report
	logic [CW-1:0]       cnt_ff [NUM_CONN];
	logic [CW-1:0]       snap_ff [NUM_CONN];
	logic [NUM_CONN-1:0] eligible;
	logic [NUM_CONN-1:0] take;
	rpt_state_t          state_ff;
	logic [NUM_CONN-1:0] pend_ff;
	logic [IW-1:0]       cur;

	generate
		for (g = 0; g < NUM_CONN; g++) begin : g_cnt
			assign eligible[g] = conn_open[g] && (cnt_ff[g] != CW'(flow_pkg::CNT_ZERO))
				&& (sco_flow_en || !conn_is_sco[g]);
			always_ff @(posedge clk) begin
				if (!rst_n || !conn_open[g]) begin
					cnt_ff[g] <= '0;
				end else if (take[g]) begin
					cnt_ff[g] <= CW'(done_evt[g]);
				end else if (done_evt[g] && cnt_ff[g] != '1) begin
					cnt_ff[g] <= cnt_ff[g] + 1'b1;
				end
			end
			// reported count is frozen so the entry stands while offered
			always_ff @(posedge clk) begin
				if (!rst_n) snap_ff[g] <= '0;
				else if (take[g]) snap_ff[g] <= cnt_ff[g];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// periodic report timer and report sequencer
	logic [PW-1:0] tmr_ff;
	logic          active;
	logic          fire;

	assign active = (|conn_open) || loopback_en;
	assign fire   = active && (tmr_ff == PW'(PERIOD_CYC - 1)) && (|eligible);

	always_ff @(posedge clk) begin
		if (!rst_n || !active) tmr_ff <= '0;
		else if (tmr_ff != PW'(PERIOD_CYC - 1)) tmr_ff <= tmr_ff + 1'b1;
		else if (state_ff == RPT_IDLE) tmr_ff <= '0;
	end

	assign cur = first_set(pend_ff);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= RPT_IDLE;
			pend_ff  <= '0;
		end else begin
			case (state_ff)
				RPT_IDLE: begin
					if (fire) begin
						pend_ff  <= eligible;
						state_ff <= RPT_SEND;
					end
				end
				RPT_SEND: begin
					if (rpt_ready) begin
						pend_ff[cur] <= 1'b0;
						if ((pend_ff & ~(NUM_CONN'(1) << cur)) == '0) state_ff <= RPT_IDLE;
					end
				end
				default: state_ff <= RPT_IDLE;
			endcase
		end
	end

	// snapshot every reported slot as the report starts
	always_comb begin
		take = '0;
		if (state_ff == RPT_IDLE && fire) take = eligible;
	end

	assign rpt_valid        = (state_ff == RPT_SEND);
	assign rpt_entry.handle = conn_handle[cur*HW +: HW];
	assign rpt_entry.count  = snap_ff[cur];
	assign rpt_last         = (pend_ff & ~(NUM_CONN'(1) << cur)) == '0;

endmodule : flow_ctrl

// *** tb/flow_checker.sv ***
// concurrent checks on the flow control block ports
`timescale 1ns/10ps
module flow_checker #(
	parameter int NUM_CONN   = 4,
	parameter int PERIOD_CYC = 8
) (
	// clock and reset
	input wire logic                           clk,
	input wire logic                           rst_n,
	// mode and connection table
	input wire logic                           loopback_en,
	input wire logic                           sco_flow_en,
	input wire logic [NUM_CONN-1:0]            conn_open,
	input wire logic [NUM_CONN-1:0]            conn_is_sco,
	input wire logic [NUM_CONN*flow_pkg::HANDLE_W-1:0] conn_handle,
	// streams
	input wire logic                           tx_valid,
	input wire logic                           tx_ready,
	input wire flow_pkg::pkt_hdr_t             tx_hdr,
	input wire logic [NUM_CONN-1:0]            tx_flush,
	input wire logic                           rx_valid,
	input wire logic                           rx_ready,
	input wire flow_pkg::pkt_hdr_t             rx_hdr,
	input wire logic                           c2h_valid,
	input wire logic                           c2h_ready,
	input wire flow_pkg::pkt_hdr_t             c2h_hdr,
	input wire logic                           rpt_valid,
	input wire logic                           rpt_ready,
	input wire flow_pkg::report_entry_t        rpt_entry,
	input wire logic                           rpt_last
);
	localparam int HW      = flow_pkg::HANDLE_W;
	localparam int RPT_MAX = 3 * PERIOD_CYC + 8;
	logic sco_hit;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_comb begin
		sco_hit = 1'b0;
		for (int i = 0; i < NUM_CONN; i++)
			sco_hit |= conn_is_sco[i] && conn_handle[i*HW+:HW] == rpt_entry.handle;
	end
	////////////////////////////////////////////////////////////////
	chk_tx_hold: assert property (tx_valid && !tx_ready && tx_flush == '0
		|=> tx_valid && $stable(tx_hdr)) else $error("tx header dropped before acceptance");
	chk_rx_forward: assert property (rx_valid && rx_ready
		|=> c2h_valid && c2h_hdr == $past(rx_hdr)) else $error("received packet not forwarded");
	chk_c2h_source: assert property ($rose(c2h_valid) |-> $past(rx_valid) && $past(rx_ready))
		else $error("host packet without a received one");
	chk_c2h_hold: assert property (c2h_valid && !c2h_ready |=> c2h_valid && $stable(c2h_hdr))
		else $error("host packet changed before acceptance");
	chk_rpt_hold: assert property (rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt_entry))
		else $error("report entry changed before acceptance");
	chk_rpt_due: assert property (tx_valid && tx_ready && tx_hdr.kind == flow_pkg::LINK_ACL
		|-> ##[1:RPT_MAX] rpt_valid) else $error("no report after a transmit");
	chk_rpt_start: assert property ($rose(rpt_valid) |-> $past(loopback_en) || $past(conn_open) != '0)
		else $error("report without connection or loopback");
	chk_sco_omit: assert property (rpt_valid && !sco_flow_en |-> !sco_hit)
		else $error("sco handle reported while sco flow is off");
	chk_rpt_more: assert property (rpt_valid && rpt_ready && !rpt_last |=> rpt_valid)
		else $error("report ended before its last entry");
	chk_rpt_end: assert property (rpt_valid && rpt_ready && rpt_last |=> !rpt_valid)
		else $error("report continued past its last entry");
endmodule : flow_checker

// *** tb/host_model.sv ***
// host driver model: credit based sender and report consumer
`timescale 1ns/10ps
module host_model #(
	parameter int TOTAL = 4 // buffer count read at start-up
) (
	// clock and reset
	input wire logic                    clk,
	input wire logic                    rst_n,
	// bench control
	input wire logic                    send_req,
	input wire flow_pkg::pkt_hdr_t      send_hdr,
	input wire logic                    stall,
	input wire logic [11:0]             sco_handle,
	// controller side
	output logic                        h2c_valid,
	input wire logic                    h2c_ready,
	output flow_pkg::pkt_hdr_t          h2c_hdr,
	input wire logic                    rpt_valid,
	output logic                        rpt_ready,
	input wire flow_pkg::report_entry_t rpt_entry,
	output logic [1:0][7:0]             credits_ff
);
	logic [1:0][8:0] nxt_credits;
	assign rpt_ready = !stall;
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			nxt_credits[k] = 9'(credits_ff[k]);
			if (h2c_valid && h2c_ready && h2c_hdr.kind == flow_pkg::link_type_t'(k))
				nxt_credits[k] = nxt_credits[k] - 9'h001;
			if (rpt_valid && rpt_ready && (rpt_entry.handle == sco_handle) == k[0])
				nxt_credits[k] = nxt_credits[k] + 9'(rpt_entry.count);
			if (nxt_credits[k] > 9'(TOTAL))
				nxt_credits[k] = 9'(TOTAL);
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n)
			credits_ff <= {8'(TOTAL), 8'(TOTAL)};
		else
			credits_ff <= {nxt_credits[1][7:0], nxt_credits[0][7:0]};
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			h2c_valid <= 1'b0;
			h2c_hdr   <= '0;
		end else if (h2c_valid && h2c_ready) begin
			h2c_valid <= 1'b0;
			h2c_hdr   <= ~h2c_hdr; // released header does not keep its value
		end else if (send_req && !h2c_valid && credits_ff[send_hdr.kind] != 8'h00) begin
			h2c_valid <= 1'b1;
			h2c_hdr   <= send_hdr; // sent in creation order
		end
	end
endmodule : host_model

// *** tb/testbench.sv ***
// top level bench for the flow control block
`timescale 1ns/10ps
module testbench;
	logic clk, rst_n, loopback_en, sco_flow_en, send_req, stall, tx_valid, tx_ready;
	logic rx_valid, rx_ready, c2h_valid, c2h_ready = 1'b0, h2c_valid, h2c_ready;
	logic rpt_valid, rpt_ready, rpt_last;
	logic [3:0] conn_open, conn_is_sco, tx_flush;
	logic [47:0] conn_handle;
	logic [1:0][7:0] credits;
	flow_pkg::pkt_hdr_t send_hdr, h2c_hdr, tx_hdr, rx_hdr, c2h_hdr;
	flow_pkg::report_entry_t rpt_entry;
	logic [11:0] rsum [4] = '{default: 12'h000};
	logic [11:0] sco_seen = 12'h000;
	logic [11:0] tx_q [$];
	logic [11:0] c2h_q [$];
	int failures, cmp_count;
	flow_ctrl #(.PERIOD_CYC(8)) flow_ctrl_i (.clk, .rst_n, .loopback_en, .sco_flow_en,
		.conn_open, .conn_is_sco, .conn_handle, .h2c_valid, .h2c_ready, .h2c_hdr, .tx_valid,
		.tx_ready, .tx_hdr, .tx_flush, .rx_valid, .rx_ready, .rx_hdr, .c2h_valid, .c2h_ready,
		.c2h_hdr, .rpt_valid, .rpt_ready, .rpt_entry, .rpt_last);
	host_model #(.TOTAL(4)) host_model_i (.clk, .rst_n, .send_req, .send_hdr, .stall,
		.sco_handle(12'h033), .h2c_valid, .h2c_ready, .h2c_hdr, .rpt_valid, .rpt_ready,
		.rpt_entry, .credits_ff(credits));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		c2h_ready <= !c2h_ready;
		if (tx_valid && tx_ready) tx_q.push_back(tx_hdr.handle);
		if (c2h_valid && c2h_ready) c2h_q.push_back(c2h_hdr.handle);
		if (rpt_valid && rpt_ready) rsum[rpt_entry.handle[5:4]] += 12'(rpt_entry.count);
		if (rpt_valid && rpt_ready && rpt_entry.handle == 12'h033) sco_seen++;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic send(input logic [11:0] h, input logic sco);
		@(posedge clk);
		send_req <= 1'b1;
		send_hdr <= '{h, flow_pkg::link_type_t'(sco)};
		for (int i = 0; i < 40 && !(h2c_valid && h2c_ready); i++) @(posedge clk);
		send_req <= 1'b0;
		@(posedge clk);
	endtask : send
	task automatic t_order;
		stall <= 1'b1;
		send(12'h011, 1'b0);
		send(12'h022, 1'b0);
		send(12'h011, 1'b0);
		check("acl credits", 12'(credits[0]), 12'h001);
		tx_ready <= 1'b1;
		repeat (20) @(posedge clk);
		stall <= 1'b0;
		check("tx count", 12'(tx_q.size()), 12'h003);
		repeat (40) @(posedge clk);
		check("done 011", rsum[1], 12'h002);
		check("done 022", rsum[2], 12'h001);
		check("credits back", 12'(credits[0]), 12'h004);
		$display("order test done");
	endtask : t_order
	task automatic t_sco;
		send(12'h033, 1'b1);
		repeat (40) @(posedge clk);
		check("sco entries", sco_seen, 12'h000);
		check("tx count", 12'(tx_q.size()), 12'h004);
		sco_flow_en <= 1'b1;
		repeat (30) @(posedge clk);
		check("sco reported", sco_seen, 12'h001);
		check("sco credits", 12'(credits[1]), 12'h004);
		$display("sco test done");
	endtask : t_sco
	task automatic t_flush;
		tx_ready <= 1'b0;
		send(12'h022, 1'b0);
		tx_flush <= 4'b0010;
		@(posedge clk);
		tx_flush <= 4'b0000;
		tx_ready <= 1'b1;
		repeat (40) @(posedge clk);
		check("flush done", rsum[2], 12'h002);
		check("not sent", 12'(tx_q.size()), 12'h004);
		check("credits back", 12'(credits[0]), 12'h004);
		$display("flush test done");
	endtask : t_flush
	task automatic t_rx;
		rx_valid <= 1'b1;
		for (int n = 0; n < 3; n++) begin
			rx_hdr <= '{12'h011 + 12'(n), flow_pkg::LINK_ACL};
			@(posedge clk);
			for (int i = 0; i < 20 && !rx_ready; i++) @(posedge clk);
		end
		rx_valid <= 1'b0;
		repeat (8) @(posedge clk);
		check("rx count", 12'(c2h_q.size()), 12'h003);
		for (int n = 0; n < 3; n++)
			check("rx order", c2h_q[n], 12'h011 + 12'(n));
		$display("receive test done");
	endtask : t_rx
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	initial begin
		{rst_n, loopback_en, sco_flow_en, send_req, stall, tx_ready, rx_valid} = '0;
		{tx_flush, send_hdr, rx_hdr} = '0;
		conn_open = 4'b0111;
		conn_is_sco = 4'b0100;
		conn_handle = {12'h044, 12'h033, 12'h022, 12'h011};
		repeat (20) @(posedge clk);
		check("tx idle", 12'(tx_valid), 12'h000);
		check("rpt idle", 12'(rpt_valid), 12'h000);
		rst_n <= 1'b1;
		t_order;
		t_sco;
		t_flush;
		t_rx;
		report_and_stop;
	end
	initial begin
		#150000;
		failures++;
		report_and_stop;
	end
endmodule : testbench
bind flow_ctrl flow_checker #(.NUM_CONN(NUM_CONN), .PERIOD_CYC(PERIOD_CYC)) flow_checker_i (
	.clk, .rst_n, .loopback_en, .sco_flow_en, .conn_open, .conn_is_sco, .conn_handle, .tx_valid,
	.tx_ready, .tx_hdr, .tx_flush, .rx_valid, .rx_ready, .rx_hdr, .c2h_valid, .c2h_ready,
	.c2h_hdr, .rpt_valid, .rpt_ready, .rpt_entry, .rpt_last);
